// ### verilog/mpsc_top.sv
// mode dependent pin roles, bus width and system control register
// assumes mode pins static after reset; cpu gives sleep and wake pulses on clk
`timescale 1ns/1ps
module mpsc_top #(
   parameter int WAIT_8K_CYC = 8192,
   parameter int WAIT_16K_CYC = 16384,
   parameter int WAIT_32K_CYC = 32768,
   parameter int WAIT_64K_CYC = 65536,
   parameter int WAIT_128K_CYC = 131072,
   parameter int WAIT_256K_CYC = 262144
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // pins
   input wire logic [2:0] mode_pin,
   input wire logic nmi_pin,
   // cpu handshake
   input wire logic sleep_req,
   input wire logic wake_irq,
   output logic nmi_irq,
   output logic user_flag_mask,
   output logic ram_enable,
   output logic standby_active,
   output logic clock_settling,
   // pin roles
   output logic bus_16bit,
   output logic [1:0] addr_space,
   output logic [7:0] port1_addr_en,
   output logic [7:0] port2_addr_en,
   output logic [3:0] port5_addr_en,
   output logic [3:0] porta_addr_en,
   output logic port3_data_en,
   output logic port4_data_en,
   // standby bus drive
   output logic addr_drive_en,
   output logic strobe_drive_en,
   output logic strobe_force_high
);
   logic [3:0] pins_s;
   logic settle_done;
   logic [7:0] sysctl_r, sysctl_nxt, awc_r, awc_nxt, brc_r, brc_nxt;
   logic [7:0] p1dir_r, p1dir_nxt, p2dir_r, p2dir_nxt, p5dir_r, p5dir_nxt;
   logic [7:0] rdata_nxt;
   logic [2:0] mode_r, mode_nxt, cap_r, cap_nxt;
   logic nmi_prev_r;
   mpsc_pkg::mpsc_state_t st_r, st_nxt;
   logic settle_load;
   logic [mpsc_pkg::CNT_W-1:0] settle_val;
   logic nmi_irq_nxt, bus16_nxt, p3_nxt, p4_nxt, adr_nxt, stb_nxt, sfh_nxt;
   logic [1:0] space_nxt;
   logic [7:0] p1_nxt, p2_nxt;
   logic [3:0] p5_nxt, pa_nxt;

   function automatic logic [mpsc_pkg::CNT_W-1:0] wait_cycles(input logic [2:0] code);
      case (code)
         mpsc_pkg::W_8K: wait_cycles = mpsc_pkg::CNT_W'(WAIT_8K_CYC);
         mpsc_pkg::W_16K: wait_cycles = mpsc_pkg::CNT_W'(WAIT_16K_CYC);
         mpsc_pkg::W_32K: wait_cycles = mpsc_pkg::CNT_W'(WAIT_32K_CYC);
         mpsc_pkg::W_64K: wait_cycles = mpsc_pkg::CNT_W'(WAIT_64K_CYC);
         mpsc_pkg::W_128K: wait_cycles = mpsc_pkg::CNT_W'(WAIT_128K_CYC);
         mpsc_pkg::W_1K: wait_cycles = mpsc_pkg::WAIT_1K_CYC;
         default: wait_cycles = mpsc_pkg::CNT_W'(WAIT_256K_CYC);
      endcase
   endfunction : wait_cycles

   mpsc_sync #(.W(4)) u_sync (
      .clk(clk),
      .reset_n(reset_n),
      .pin({nmi_pin, mode_pin}),
      .value(pins_s)
   );

   mpsc_settle u_settle (
      .clk(clk),
      .reset_n(reset_n),
      .load(settle_load),
      .load_val(settle_val),
      .done(settle_done)
   );

   // registers and mode strap
   always_comb begin
      sysctl_nxt = sysctl_r;
      awc_nxt = awc_r;
      brc_nxt = brc_r;
      p1dir_nxt = p1dir_r;
      p2dir_nxt = p2dir_r;
      p5dir_nxt = p5dir_r;
      mode_nxt = mode_r;
      cap_nxt = cap_r;
      rdata_nxt = mpsc_pkg::BYTE_NONE;
      // strap caught after release, once the synchroniser has filled
      if (cap_r != mpsc_pkg::CAPTURE_CYC) begin
         cap_nxt = cap_r + 3'h1;
         if (cap_nxt == mpsc_pkg::CAPTURE_CYC) begin
            mode_nxt = pins_s[2:0];
            awc_nxt = (pins_s[2:0] == 3'h2 || pins_s[2:0] == 3'h4) ?
                      mpsc_pkg::AWC_ALL16 : mpsc_pkg::AWC_ALL8;
         end
      end
      if (reg_wr) begin
         case (reg_addr)
            mpsc_pkg::REG_SYSCTL: sysctl_nxt = reg_wdata;
            mpsc_pkg::REG_AWC: awc_nxt = reg_wdata;
            mpsc_pkg::REG_BRC: brc_nxt = reg_wdata;
            mpsc_pkg::REG_P1DIR: p1dir_nxt = reg_wdata;
            mpsc_pkg::REG_P2DIR: p2dir_nxt = reg_wdata;
            mpsc_pkg::REG_P5DIR: p5dir_nxt = {4'h0, reg_wdata[3:0]};
            default: ;
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            mpsc_pkg::REG_SYSCTL: rdata_nxt = sysctl_r;
            mpsc_pkg::REG_AWC: rdata_nxt = awc_r;
            mpsc_pkg::REG_BRC: rdata_nxt = brc_r;
            mpsc_pkg::REG_P1DIR: rdata_nxt = p1dir_r;
            mpsc_pkg::REG_P2DIR: rdata_nxt = p2dir_r;
            mpsc_pkg::REG_P5DIR: rdata_nxt = p5dir_r;
            mpsc_pkg::REG_STATUS: rdata_nxt = {bus_16bit, st_r, mode_r, 2'h0};
            default: rdata_nxt = mpsc_pkg::BYTE_NONE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         sysctl_r <= mpsc_pkg::SYSCTL_RST;
         awc_r <= mpsc_pkg::AWC_ALL8;
         brc_r <= mpsc_pkg::BRC_RST;
         p1dir_r <= mpsc_pkg::BYTE_NONE;
         p2dir_r <= mpsc_pkg::BYTE_NONE;
         p5dir_r <= mpsc_pkg::BYTE_NONE;
         mode_r <= 3'h0;
         cap_r <= 3'h0;
         reg_rdata <= mpsc_pkg::BYTE_NONE;
      end else begin
         sysctl_r <= sysctl_nxt;
         awc_r <= awc_nxt;
         brc_r <= brc_nxt;
         p1dir_r <= p1dir_nxt;
         p2dir_r <= p2dir_nxt;
         p5dir_r <= p5dir_nxt;
         mode_r <= mode_nxt;
         cap_r <= cap_nxt;
         reg_rdata <= rdata_nxt;
      end
   end

   // standby sequencing; arm and ram bits are left alone here
   always_comb begin
      st_nxt = st_r;
      settle_load = 1'b0;
      settle_val = wait_cycles(sysctl_r[mpsc_pkg::B_WAIT_HI:mpsc_pkg::B_WAIT_LO]);
      case (st_r)
         mpsc_pkg::MPSC_RUN: begin
            if (sleep_req && sysctl_r[mpsc_pkg::B_ARM]) begin
               st_nxt = mpsc_pkg::MPSC_STBY;
            end
         end
         mpsc_pkg::MPSC_STBY: begin
            if (wake_irq) begin
               st_nxt = mpsc_pkg::MPSC_SETTLE;
               settle_load = 1'b1;
            end
         end
         mpsc_pkg::MPSC_SETTLE: begin
            if (settle_done) begin
               st_nxt = mpsc_pkg::MPSC_RUN;
            end
         end
         default: st_nxt = mpsc_pkg::MPSC_RUN;
      endcase
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_r <= mpsc_pkg::MPSC_RUN;
      end else begin
         st_r <= st_nxt;
      end
   end

   // pin roles, all registered so pads see no decode glitches
   always_comb begin
      nmi_irq_nxt = sysctl_r[mpsc_pkg::B_NMIEDGE] ? (pins_s[3] && !nmi_prev_r) :
                    (!pins_s[3] && nmi_prev_r);
      bus16_nxt = |awc_r;
      p1_nxt = mpsc_pkg::BYTE_NONE;
      p2_nxt = mpsc_pkg::BYTE_NONE;
      p5_nxt = mpsc_pkg::NIB_NONE;
      pa_nxt = mpsc_pkg::NIB_NONE;
      p3_nxt = 1'b0;
      p4_nxt = 1'b0;
      space_nxt = mpsc_pkg::SPACE_1M;
      case (mode_r)
         3'h1, 3'h2: begin
            p1_nxt = mpsc_pkg::BYTE_ALL;
            p2_nxt = mpsc_pkg::BYTE_ALL;
            p5_nxt = mpsc_pkg::NIB_ALL;
            p3_nxt = 1'b1;
            p4_nxt = bus16_nxt;
         end
         3'h3, 3'h4: begin
            p1_nxt = mpsc_pkg::BYTE_ALL;
            p2_nxt = mpsc_pkg::BYTE_ALL;
            p5_nxt = mpsc_pkg::NIB_ALL;
            pa_nxt = {~brc_r[7:5], 1'b1};
            p3_nxt = 1'b1;
            p4_nxt = bus16_nxt;
            space_nxt = mpsc_pkg::SPACE_16M;
         end
         3'h5: begin
            p1_nxt = p1dir_r;
            p2_nxt = p2dir_r;
            p5_nxt = p5dir_r[3:0];
            pa_nxt = ~brc_r[7:4];
            p3_nxt = 1'b1;
            p4_nxt = bus16_nxt;
            space_nxt = mpsc_pkg::SPACE_16M;
         end
         3'h6: space_nxt = mpsc_pkg::SPACE_64K;
         default: space_nxt = mpsc_pkg::SPACE_1M;
      endcase
      adr_nxt = 1'b1;
      stb_nxt = 1'b1;
      sfh_nxt = 1'b0;
      if (st_nxt != mpsc_pkg::MPSC_RUN) begin
         adr_nxt = sysctl_r[mpsc_pkg::B_HOLD];
         stb_nxt = sysctl_r[mpsc_pkg::B_HOLD];
         sfh_nxt = sysctl_r[mpsc_pkg::B_HOLD];
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         nmi_prev_r <= 1'b0;
         nmi_irq <= 1'b0;
         user_flag_mask <= 1'b0;
         ram_enable <= 1'b1;
         standby_active <= 1'b0;
         clock_settling <= 1'b0;
         bus_16bit <= 1'b0;
         addr_space <= mpsc_pkg::SPACE_1M;
         port1_addr_en <= mpsc_pkg::BYTE_NONE;
         port2_addr_en <= mpsc_pkg::BYTE_NONE;
         port5_addr_en <= mpsc_pkg::NIB_NONE;
         porta_addr_en <= mpsc_pkg::NIB_NONE;
         port3_data_en <= 1'b0;
         port4_data_en <= 1'b0;
         addr_drive_en <= 1'b1;
         strobe_drive_en <= 1'b1;
         strobe_force_high <= 1'b0;
      end else begin
         nmi_prev_r <= pins_s[3];
         nmi_irq <= nmi_irq_nxt;
         user_flag_mask <= !sysctl_r[mpsc_pkg::B_UFS];
         ram_enable <= sysctl_r[mpsc_pkg::B_RAM];
         standby_active <= (st_nxt == mpsc_pkg::MPSC_STBY);
         clock_settling <= (st_nxt == mpsc_pkg::MPSC_SETTLE);
         bus_16bit <= bus16_nxt;
         addr_space <= space_nxt;
         port1_addr_en <= p1_nxt;
         port2_addr_en <= p2_nxt;
         port5_addr_en <= p5_nxt;
         porta_addr_en <= pa_nxt;
         port3_data_en <= p3_nxt;
         port4_data_en <= p4_nxt;
         addr_drive_en <= adr_nxt;
         strobe_drive_en <= stb_nxt;
         strobe_force_high <= sfh_nxt;
      end
   end

   // checks
   logic [mpsc_pkg::CNT_W-1:0] chk_cnt_r;
   logic [mpsc_pkg::CNT_W-1:0] chk_want_r;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         chk_cnt_r <= mpsc_pkg::CNT_ZERO;
         chk_want_r <= mpsc_pkg::CNT_ZERO;
      end else if (settle_load) begin
         chk_cnt_r <= mpsc_pkg::CNT_ZERO;
         chk_want_r <= settle_val;
      end else if (st_r == mpsc_pkg::MPSC_SETTLE) begin
         chk_cnt_r <= chk_cnt_r + mpsc_pkg::CNT_ONE;
      end
   end

   property p_arm_kept;
      @(posedge clk) disable iff (!reset_n)
      (st_r == mpsc_pkg::MPSC_SETTLE && settle_done && !reg_wr) |=> sysctl_r[mpsc_pkg::B_ARM];
   endproperty
   a_arm_kept: assert property (p_arm_kept) else $error("arm bit lost on exit");

   localparam logic [mpsc_pkg::CNT_W-1:0] CNT_ONE_L = mpsc_pkg::CNT_ONE;
   property p_settle_len;
      @(posedge clk) disable iff (!reset_n)
      (st_r == mpsc_pkg::MPSC_SETTLE && settle_done) |-> (chk_cnt_r + CNT_ONE_L == chk_want_r);
   endproperty
   a_settle_len: assert property (p_settle_len) else $error("settle length wrong");

   property p_user;
      @(posedge clk) disable iff (!reset_n)
      ##1 (user_flag_mask == !$past(sysctl_r[mpsc_pkg::B_UFS]));
   endproperty
   a_user: assert property (p_user) else $error("user flag role wrong");

   property p_nmi;
      @(posedge clk) disable iff (!reset_n)
      nmi_irq |-> ($past(pins_s[3], 1) == $past(sysctl_r[mpsc_pkg::B_NMIEDGE], 1)) &&
                  ($past(pins_s[3], 2) != $past(sysctl_r[mpsc_pkg::B_NMIEDGE], 1));
   endproperty
   a_nmi: assert property (p_nmi) else $error("nmi on wrong edge");

   property p_hold;
      @(posedge clk) disable iff (!reset_n)
      standby_active |-> (addr_drive_en == strobe_force_high) &&
                         (strobe_drive_en == $past(sysctl_r[mpsc_pkg::B_HOLD]));
   endproperty
   a_hold: assert property (p_hold) else $error("standby drive wrong");

   property p_ram;
      @(posedge clk) disable iff (!reset_n)
      (st_r != $past(st_r) && !$past(reg_wr)) |-> $stable(sysctl_r[mpsc_pkg::B_RAM]);
   endproperty
   a_ram: assert property (p_ram) else $error("ram enable moved by standby");

   property p_width;
      @(posedge clk) disable iff (!reset_n)
      (mode_r inside {3'h1, 3'h2, 3'h3, 3'h4, 3'h5}) |=> (port4_data_en == |$past(awc_r));
   endproperty
   a_width: assert property (p_width) else $error("bus width wrong");

   property p_addr12;
      @(posedge clk) disable iff (!reset_n)
      (mode_r == 3'h1 || mode_r == 3'h2) ##1 $stable(mode_r) |->
         (port1_addr_en == mpsc_pkg::BYTE_ALL) && (porta_addr_en == mpsc_pkg::NIB_NONE);
   endproperty
   a_addr12: assert property (p_addr12) else $error("modes 1 2 address roles");

   property p_addr34;
      @(posedge clk) disable iff (!reset_n)
      (mode_r == 3'h3 || mode_r == 3'h4) |=> porta_addr_en[0] &&
         (porta_addr_en[3:1] == ~$past(brc_r[7:5]));
   endproperty
   a_addr34: assert property (p_addr34) else $error("a20 to a23 roles wrong");

   property p_mode5;
      @(posedge clk) disable iff (!reset_n)
      (mode_r == 3'h5) |=> (port1_addr_en == $past(p1dir_r)) &&
         (porta_addr_en == ~$past(brc_r[7:4]));
   endproperty
   a_mode5: assert property (p_mode5) else $error("mode 5 roles wrong");

   property p_single;
      @(posedge clk) disable iff (!reset_n)
      (mode_r == 3'h6) |=> (port1_addr_en == mpsc_pkg::BYTE_NONE) && !port3_data_en &&
         (addr_space == mpsc_pkg::SPACE_64K);
   endproperty
   a_single: assert property (p_single) else $error("mode 6 roles wrong");

   c_standby: cover property (@(posedge clk) disable iff (!reset_n)
      st_r == mpsc_pkg::MPSC_STBY ##1 st_r == mpsc_pkg::MPSC_SETTLE);
   c_wake: cover property (@(posedge clk) disable iff (!reset_n)
      st_r == mpsc_pkg::MPSC_SETTLE && settle_done);
   c_nmi: cover property (@(posedge clk) disable iff (!reset_n) nmi_irq);
   c_bus16: cover property (@(posedge clk) disable iff (!reset_n) $rose(bus_16bit));
endmodule : mpsc_top

// ### verilog/mpsc_pkg.sv
// mode pin function and system control: shared constants
// assumes one 100 MHz clock; one wait state equals one clock
package mpsc_pkg;
   // register index on the plain register port
   localparam logic [3:0] REG_SYSCTL = 4'h0;
   localparam logic [3:0] REG_AWC = 4'h1;
   localparam logic [3:0] REG_BRC = 4'h2;
   localparam logic [3:0] REG_P1DIR = 4'h3;
   localparam logic [3:0] REG_P2DIR = 4'h4;
   localparam logic [3:0] REG_P5DIR = 4'h5;
   localparam logic [3:0] REG_STATUS = 4'h6;
   // system_control fields
   localparam int B_ARM = 7;
   localparam int B_WAIT_HI = 6;
   localparam int B_WAIT_LO = 4;
   localparam int B_UFS = 3;
   localparam int B_NMIEDGE = 2;
   localparam int B_HOLD = 1;
   localparam int B_RAM = 0;
   localparam logic [7:0] SYSCTL_RST = 8'h09;
   // bus_release_control: ones keep port a upper pins as general i/o, except the bit 4 pin, which stays address in modes 3 and 4
   localparam logic [7:0] BRC_RST = 8'hf0;
   localparam logic [7:0] AWC_ALL16 = 8'hff;
   localparam logic [7:0] AWC_ALL8 = 8'h00;
   localparam logic [7:0] BYTE_ALL = 8'hff;
   localparam logic [3:0] NIB_ALL = 4'hf;
   localparam logic [7:0] BYTE_NONE = 8'h00;
   localparam logic [3:0] NIB_NONE = 4'h0;
   // settle wait codes
   localparam logic [2:0] W_8K = 3'h0;
   localparam logic [2:0] W_16K = 3'h1;
   localparam logic [2:0] W_32K = 3'h2;
   localparam logic [2:0] W_64K = 3'h3;
   localparam logic [2:0] W_128K = 3'h4;
   localparam logic [2:0] W_256K = 3'h5;
   localparam logic [2:0] W_1K = 3'h6;
   localparam int CNT_W = 19;
   localparam int STATE_CLKS = 1;
   localparam int WAIT_1K_STATES = 1024;
   localparam logic [CNT_W-1:0] WAIT_1K_CYC = CNT_W'(WAIT_1K_STATES * STATE_CLKS);
   localparam logic [CNT_W-1:0] CNT_ONE = 19'h00001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 19'h00000;
   // mode pin captures wait for the pin synchroniser to settle
   localparam logic [2:0] CAPTURE_CYC = 3'h5;
   // address space codes
   localparam logic [1:0] SPACE_64K = 2'h0;
   localparam logic [1:0] SPACE_1M = 2'h1;
   localparam logic [1:0] SPACE_16M = 2'h2;
   typedef enum logic [1:0] {
      MPSC_RUN = 2'b00,
      MPSC_STBY = 2'b01,
      MPSC_SETTLE = 2'b11
   } mpsc_state_t;
endpackage : mpsc_pkg

// ### verilog/mpsc_sync.sv
// three-flop pin synchroniser with agreement filter
// assumes pins asynchronous to clk; output follows once stages two and three agree
`timescale 1ns/1ps
module mpsc_sync #(
   parameter int W = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // pins and filtered result
   input wire logic [W-1:0] pin,
   output logic [W-1:0] value
);
   logic [W-1:0] s1_r;
   logic [W-1:0] s2_r;
   logic [W-1:0] s3_r;
   logic [W-1:0] value_nxt;

   always_comb begin
      value_nxt = value;
      for (int i = 0; i < W; i++) begin
         if (s2_r[i] == s3_r[i]) begin
            value_nxt[i] = s3_r[i];
         end
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         value <= '0;
      end else begin
         s1_r <= pin;
         s2_r <= s1_r;
         s3_r <= s2_r;
         value <= value_nxt;
      end
   end
endmodule : mpsc_sync

// ### verilog/mpsc_settle.sv
// oscillator settle down-counter
// assumes load is a single-cycle pulse; done pulses in the last counted cycle
`timescale 1ns/1ps
module mpsc_settle (
   // clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // control
   input wire logic load,
   input wire logic [mpsc_pkg::CNT_W-1:0] load_val,
   output logic done
);
   logic [mpsc_pkg::CNT_W-1:0] cnt_r;
   logic [mpsc_pkg::CNT_W-1:0] cnt_nxt;

   always_comb begin
      cnt_nxt = cnt_r;
      if (load) begin
         cnt_nxt = load_val;
      end else if (cnt_r != mpsc_pkg::CNT_ZERO) begin
         cnt_nxt = cnt_r - mpsc_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_r <= mpsc_pkg::CNT_ZERO;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign done = !load && (cnt_r == mpsc_pkg::CNT_ONE);
endmodule : mpsc_settle

// ### sim/mpsc_pins.sv
// strap pins and nmi source standing outside the block
// assumes the bench gives strap and nmi levels on clk
`timescale 1ns/1ps
module mpsc_pins (
   // clock
   input wire logic clk,
   // requested levels
   input wire logic [2:0] strap,
   input wire logic nmi_lvl,
   // pins
   output logic [2:0] mode_pin,
   output logic nmi_pin
);
   // straps are set well before reset release
   assign mode_pin = strap;
   initial nmi_pin = 1'b1;
   // edge lands off the clock, like a truly async source
   always @(posedge clk) nmi_pin <= #2 nmi_lvl;
endmodule : mpsc_pins

// ### sim/mpsc_test.sv
// self-checking bench for mode pin roles and system control
// assumes mpsc_top with shortened settle waits and mpsc_pins as strap source
`timescale 1ns/1ps
module mpsc_test;
   logic clk = 1'b0;
   logic reset_n = 1'b0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [2:0] strap = 3'h7;
   logic nmi_lvl = 1'b1;
   logic [2:0] mode_pin;
   logic nmi_pin;
   logic sleep_req = 1'b0;
   logic wake_irq = 1'b0;
   logic nmi_irq, user_flag_mask, ram_enable, standby_active, clock_settling;
   logic bus_16bit, port3_data_en, port4_data_en;
   logic addr_drive_en, strobe_drive_en, strobe_force_high;
   logic [1:0] addr_space;
   logic [7:0] port1_addr_en, port2_addr_en;
   logic [3:0] port5_addr_en, porta_addr_en;
   int error_cnt = 0;
   int samples_checked = 0;
   always #5 clk = ~clk;
   mpsc_pins pins (.clk, .strap, .nmi_lvl, .mode_pin, .nmi_pin);
   // code 000 keeps its full count so one wait of true length is timed
   mpsc_top #(.WAIT_16K_CYC(16), .WAIT_32K_CYC(32),
      .WAIT_64K_CYC(64), .WAIT_128K_CYC(128), .WAIT_256K_CYC(256)) dut (
      .clk, .reset_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .mode_pin, .nmi_pin, .sleep_req, .wake_irq, .nmi_irq, .user_flag_mask,
      .ram_enable, .standby_active, .clock_settling, .bus_16bit, .addr_space,
      .port1_addr_en, .port2_addr_en, .port5_addr_en, .porta_addr_en,
      .port3_data_en, .port4_data_en, .addr_drive_en, .strobe_drive_en,
      .strobe_force_high);
   task automatic test_done();
      $display("checks=%0d errors=%0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask : rd
   task automatic boot(input logic [2:0] m);
      reset_n <= 1'b0;
      strap <= m;
      repeat (16) @(posedge clk);
      reset_n <= 1'b1;
      repeat (8) @(posedge clk);
   endtask : boot
   // dat is {bus_16bit, port3_data_en, port4_data_en}
   task automatic roles(input logic [7:0] p12, input logic [3:0] p5, pa, input logic [2:0] dat);
      repeat (2) @(posedge clk);
      #1 chk(port1_addr_en, p12);
      chk(port2_addr_en, p12);
      chk({4'h0, port5_addr_en}, {4'h0, p5});
      chk({4'h0, porta_addr_en}, {4'h0, pa});
      chk({5'h0, bus_16bit, port3_data_en, port4_data_en}, {5'h0, dat});
   endtask : roles
   task automatic t_modes();
      logic [2:0] m;
      logic w, ext;
      for (int i = 1; i < 8; i++) begin
         m = 3'(i);
         w = (m == 3'h2) || (m == 3'h4);
         ext = (m == 3'h3) || (m == 3'h4);
         boot(m);
         roles(m < 3'h5 ? 8'hff : 8'h00, m < 3'h5 ? 4'hf : 4'h0, {3'h0, ext}, {w, m < 3'h6, w});
         chk({6'h0, addr_space}, m == 3'h6 ? 8'h00 : (ext || m == 3'h5) ? 8'h02 : 8'h01);
         chk({6'h0, user_flag_mask, ram_enable}, 8'h01);
         rd(mpsc_pkg::REG_SYSCTL, 8'h09);
         rd(mpsc_pkg::REG_AWC, w ? 8'hff : 8'h00);
         rd(mpsc_pkg::REG_STATUS, {w, 2'b00, m, 2'b00});
      end
      // unmapped index: write dropped, read empty
      wr(4'h7, 8'h00);
      rd(4'h7, 8'h00);
      rd(mpsc_pkg::REG_SYSCTL, 8'h09);
   endtask : t_modes
   task automatic t_width();
      boot(3'h1);
      wr(mpsc_pkg::REG_AWC, 8'h01);
      roles(8'hff, 4'hf, 4'h0, 3'b111);
      boot(3'h2);
      wr(mpsc_pkg::REG_AWC, 8'hfe);
      roles(8'hff, 4'hf, 4'h0, 3'b111);
      wr(mpsc_pkg::REG_AWC, 8'h00);
      roles(8'hff, 4'hf, 4'h0, 3'b010);
   endtask : t_width
   task automatic t_release();
      boot(3'h3);
      wr(mpsc_pkg::REG_BRC, 8'h80);
      roles(8'hff, 4'hf, 4'h7, 3'b010);
      boot(3'h5);
      wr(mpsc_pkg::REG_P1DIR, 8'h5a);
      wr(mpsc_pkg::REG_P2DIR, 8'h5a);
      wr(mpsc_pkg::REG_P5DIR, 8'hfa);
      wr(mpsc_pkg::REG_BRC, 8'he0);
      roles(8'h5a, 4'ha, 4'h1, 3'b010);
      rd(mpsc_pkg::REG_P5DIR, 8'h0a);
   endtask : t_release
   task automatic sleep();
      @(posedge clk);
      sleep_req <= 1'b1;
      @(posedge clk);
      sleep_req <= 1'b0;
   endtask : sleep
   task automatic t_standby();
      int n;
      int lim [7] = '{8192, 16, 32, 64, 128, 256, 1024};
      logic [7:0] v;
      boot(3'h7);
      for (int c = 0; c < 7; c++) begin
         // wait code 111 never used
         v = {1'b1, 3'(c), 2'b10, 1'(c), 1'b1};
         wr(mpsc_pkg::REG_SYSCTL, v);
         sleep();
         #1 chk({4'h0, standby_active, addr_drive_en, strobe_drive_en, strobe_force_high}, {4'h0, 1'b1, {3{1'(c)}}});
         repeat (3) @(posedge clk);
         wake_irq <= 1'b1;
         @(posedge clk);
         wake_irq <= 1'b0;
         n = 0;
         #1;
         while (clock_settling === 1'b1 && n < 9000) begin
            @(posedge clk);
            #1 n++;
         end
         chk({7'h0, n >= lim[c] - 1 && n <= lim[c] + 2}, 8'h01);
         chk({4'h0, standby_active, addr_drive_en, strobe_drive_en, strobe_force_high}, 8'h06);
         rd(mpsc_pkg::REG_SYSCTL, v);
         chk({7'h0, ram_enable}, 8'h01);
      end
      // disarmed: sleep request must be ignored
      wr(mpsc_pkg::REG_SYSCTL, 8'h09);
      sleep();
      #1 chk({7'h0, standby_active}, 8'h00);
   endtask : t_standby
   task automatic t_nmi();
      int hits;
      for (int e = 0; e < 2; e++) begin
         wr(mpsc_pkg::REG_SYSCTL, {5'h00, 1'(e), 2'b01});
         repeat (2) @(posedge clk);
         #1 chk({7'h0, user_flag_mask}, 8'h01);
         for (int lv = 0; lv < 2; lv++) begin
            hits = 0;
            @(posedge clk);
            nmi_lvl <= 1'(lv);
            repeat (12) begin
               @(posedge clk);
               #1 hits += (nmi_irq === 1'b1);
            end
            chk(8'(hits), {7'h0, lv == e});
         end
      end
   endtask : t_nmi
   // longest legal path is about ten thousand cycles
   initial begin
      #300000;
      error_cnt++;
      test_done();
   end
   initial begin
      t_modes();
      t_width();
      t_release();
      t_standby();
      t_nmi();
      test_done();
   end
endmodule : mpsc_test
